// >>> hdl/apc_pkg.sv
package apc_pkg;
    // register byte addresses (index times four)
    localparam logic [3:0] POWER_DOWN_IDX = 4'h1;
    localparam logic [3:0] PROTOCOL_IDX = 4'h2;
    localparam logic [3:0] LANE_IDX = 4'h3;
    localparam logic [5:0] POWER_DOWN_ADDR = {POWER_DOWN_IDX, 2'b00};
    localparam logic [5:0] PROTOCOL_ADDR = {PROTOCOL_IDX, 2'b00};
    localparam logic [5:0] LANE_ADDR = {LANE_IDX, 2'b00};
    // field positions
    localparam int PD_MID_REF_BIT = 5;
    localparam int PD_CHAN_B_BIT = 3;
    localparam int PD_CHAN_A_BIT = 1;
    localparam int PD_INT_REF_BIT = 0;
    localparam int PROTO_SEL_LSB = 4;
    localparam int CLK_POL_BIT = 1;
    localparam int CLK_PHA_BIT = 0;
    localparam int LANE_CNT_LSB = 0;
    // writable masks and reset values
    localparam logic [7:0] POWER_DOWN_MASK = 8'h2b;
    localparam logic [7:0] PROTOCOL_MASK = 8'h73;
    localparam logic [7:0] LANE_MASK = 8'h03;
    localparam logic [7:0] POWER_DOWN_RESET = 8'h00;
    localparam logic [7:0] PROTOCOL_RESET = 8'h00;
    localparam logic [7:0] LANE_RESET = 8'h00;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        APC_PROTO_SPI_SDR = 5'h01,
        APC_PROTO_SPI_DDR = 5'h02,
        APC_PROTO_CRT_SDR = 5'h04,
        APC_PROTO_CRT_DDR = 5'h08,
        APC_PROTO_PARALLEL = 5'h10
    } apc_proto_t;

    typedef struct packed {
        logic mid_reference_power_off;
        logic channel_b_power_off;
        logic channel_a_power_off;
        logic internal_reference_power_off;
    } apc_power_t;

    typedef struct packed {
        apc_proto_t protocol;
        logic serial_clock_polarity;
        logic serial_clock_phase;
        logic [3:0] lanes_per_channel;
        logic [7:0] active_lane_mask;
    } apc_readout_t;
endpackage

// >>> hdl/apc_config_regs.sv
// Functional notes
// - power register bit 5 set powers down the mid-reference output buffer.
// - power register bit 3 set powers down channel B converter and buffer.
// - power register bit 1 set powers down channel A converter and buffer.
// - power register bit 0 set powers down the internal reference.
// - host avoids reserved bits; they read zero; writable fields reset to zero.
// - protocol field 000b selects standard serial single data rate.
// - protocol field 001b selects serial double data rate.
// - protocol field 010b selects clock re-timer single data rate.
// - protocol field 011b selects clock re-timer double data rate.
// - protocol field with top bit set selects parallel byte.
// - protocol bit 1 sets serial clock polarity for writes and reads.
// - protocol bit 0 sets serial clock phase for writes and reads.
// - lane field 00b or 01b selects one line per channel.
// - lane field 10b selects two lines per channel.
// - lane field 11b selects four lines per channel.
// - parallel byte ignores lane field and drives all eight lines.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module apc_config_regs #(
    parameter int ADDR_W = 6
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // decoded controls
    output apc_pkg::apc_power_t power_out,
    output apc_pkg::apc_readout_t readout_out
);

    // the decode needs the full six-bit byte offset
    if (ADDR_W < 6) begin : g_addr_w_check
        $error("ADDR_W must be at least 6");
    end

    logic [7:0] power_down_reg;
    logic [7:0] protocol_reg;
    logic [7:0] lane_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic aw_held_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    logic w_held_reg;
    logic write_go;
    logic [1:0] widx_next;
    logic [1:0] ridx_next;
    apc_pkg::apc_power_t power_next;
    apc_pkg::apc_readout_t readout_next;

    // 1..3 for mapped registers, 0 for unmapped
    function automatic logic [1:0] decode_addr(input logic [ADDR_W-1:0] addr);
        logic [1:0] idx;
        idx = 2'h0;
        if ((addr >> 6) != '0) begin
            idx = 2'h0;
        end else if (addr[5:0] == apc_pkg::POWER_DOWN_ADDR) begin
            idx = 2'h1;
        end else if (addr[5:0] == apc_pkg::PROTOCOL_ADDR) begin
            idx = 2'h2;
        end else if (addr[5:0] == apc_pkg::LANE_ADDR) begin
            idx = 2'h3;
        end
        return idx;
    endfunction

    assign write_go = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
    assign widx_next = decode_addr(aw_addr_reg);
    assign ridx_next = decode_addr(s_axi_araddr_in);

    // write address capture
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            s_axi_awready_out <= 1'b0;
        end else if (write_go) begin
            aw_held_reg <= 1'b0;
            s_axi_awready_out <= 1'b0;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
        end else begin
            s_axi_awready_out <= !aw_held_reg && !s_axi_bvalid_out;
        end
    end

    // write data capture
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
            s_axi_wready_out <= 1'b0;
        end else if (write_go) begin
            w_held_reg <= 1'b0;
            s_axi_wready_out <= 1'b0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_in[7:0];
            w_lane0_reg <= s_axi_wstrb_in[0];
            s_axi_wready_out <= 1'b0;
        end else begin
            s_axi_wready_out <= !w_held_reg && !s_axi_bvalid_out;
        end
    end

    // write response
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= apc_pkg::RESP_OKAY;
        end else if (write_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (widx_next == 2'h0) ? apc_pkg::RESP_SLVERR : apc_pkg::RESP_OKAY;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // register storage; reserved bits never stored, so they read zero
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            power_down_reg <= apc_pkg::POWER_DOWN_RESET;
            protocol_reg <= apc_pkg::PROTOCOL_RESET;
            lane_reg <= apc_pkg::LANE_RESET;
        end else if (write_go && w_lane0_reg) begin
            if (widx_next == 2'h1) begin
                power_down_reg <= w_data_reg & apc_pkg::POWER_DOWN_MASK;
            end else if (widx_next == 2'h2) begin
                protocol_reg <= w_data_reg & apc_pkg::PROTOCOL_MASK;
            end else if (widx_next == 2'h3) begin
                lane_reg <= w_data_reg & apc_pkg::LANE_MASK;
            end
        end
    end

    // read channel
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= apc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= (ridx_next == 2'h0) ? apc_pkg::RESP_SLVERR : apc_pkg::RESP_OKAY;
            if (ridx_next == 2'h1) begin
                s_axi_rdata_out <= {24'h000000, power_down_reg};
            end else if (ridx_next == 2'h2) begin
                s_axi_rdata_out <= {24'h000000, protocol_reg};
            end else if (ridx_next == 2'h3) begin
                s_axi_rdata_out <= {24'h000000, lane_reg};
            end else begin
                s_axi_rdata_out <= 32'h0000_0000;
            end
        end else if (s_axi_rvalid_out) begin
            if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end else begin
            s_axi_arready_out <= 1'b1;
        end
    end

    // power controls
    always_comb begin
        power_next.mid_reference_power_off = power_down_reg[apc_pkg::PD_MID_REF_BIT];
        power_next.channel_b_power_off = power_down_reg[apc_pkg::PD_CHAN_B_BIT];
        power_next.channel_a_power_off = power_down_reg[apc_pkg::PD_CHAN_A_BIT];
        power_next.internal_reference_power_off = power_down_reg[apc_pkg::PD_INT_REF_BIT];
    end

    // readout decode
    always_comb begin
        logic [2:0] sel;
        logic [1:0] lanes;
        sel = protocol_reg[apc_pkg::PROTO_SEL_LSB +: 3];
        lanes = lane_reg[apc_pkg::LANE_CNT_LSB +: 2];
        readout_next.serial_clock_polarity = protocol_reg[apc_pkg::CLK_POL_BIT];
        readout_next.serial_clock_phase = protocol_reg[apc_pkg::CLK_PHA_BIT];
        if (sel[2]) begin
            readout_next.protocol = apc_pkg::APC_PROTO_PARALLEL;
        end else begin
            case (sel[1:0])
                2'h0: readout_next.protocol = apc_pkg::APC_PROTO_SPI_SDR;
                2'h1: readout_next.protocol = apc_pkg::APC_PROTO_SPI_DDR;
                2'h2: readout_next.protocol = apc_pkg::APC_PROTO_CRT_SDR;
                default: readout_next.protocol = apc_pkg::APC_PROTO_CRT_DDR;
            endcase
        end
        if (sel[2]) begin
            readout_next.lanes_per_channel = 4'h4;
            readout_next.active_lane_mask = 8'hff;
        end else if (lanes == 2'h3) begin
            readout_next.lanes_per_channel = 4'h4;
            readout_next.active_lane_mask = 8'hff;
        end else if (lanes == 2'h2) begin
            readout_next.lanes_per_channel = 4'h2;
            readout_next.active_lane_mask = 8'h33;
        end else begin
            readout_next.lanes_per_channel = 4'h1;
            readout_next.active_lane_mask = 8'h11;
        end
    end

    // registered control outputs
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            power_out <= '0;
            readout_out <= '{protocol: apc_pkg::APC_PROTO_SPI_SDR, serial_clock_polarity: 1'b0,
                serial_clock_phase: 1'b0, lanes_per_channel: 4'h1, active_lane_mask: 8'h11};
        end else begin
            power_out <= power_next;
            readout_out <= readout_next;
        end
    end

endmodule
`default_nettype wire

// >>> tb/apc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module apc_monitor (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // bus answers
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    // decoded controls
    input wire apc_pkg::apc_power_t power_out,
    input wire apc_pkg::apc_readout_t readout_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire logic par = readout_out.protocol == apc_pkg::APC_PROTO_PARALLEL;
    wire logic [3:0] lanes = readout_out.lanes_per_channel;
    wire logic [7:0] lmask = readout_out.active_lane_mask;
    proto_onehot_a: assert property ($onehot(readout_out.protocol))
        else $error("protocol select not one-hot");
    par_lanes_a: assert property (par |-> lmask == 8'hff && lanes == 4'h4)
        else $error("parallel byte not on all lines");
    one_lane_a: assert property (!par && lanes == 4'h1 |-> lmask == 8'h11)
        else $error("single lane mask wrong");
    two_lane_a: assert property (!par && lanes == 4'h2 |-> lmask == 8'h33)
        else $error("dual lane mask wrong");
    four_lane_a: assert property (!par && lanes == 4'h4 |-> lmask == 8'hff)
        else $error("quad lane mask wrong");
    rd_reserved_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
        else $error("upper read bits not zero");
    reset_val_a: assert property ($rose(rstn_in) |-> power_out == 4'h0 && !par && lanes == 4'h1)
        else $error("controls not at reset value");
    pwr_after_wr_a: assert property ($changed(power_out) |-> $past(s_axi_bvalid_out))
        else $error("power controls moved without a write");
    cfg_after_wr_a: assert property ($changed(readout_out) |-> $past(s_axi_bvalid_out))
        else $error("readout controls moved without a write");
    cover property (par);
    cover property (s_axi_bvalid_out && s_axi_bresp_out == apc_pkg::RESP_SLVERR);
    cover property (!par && lanes == 4'h2);
endmodule
bind apc_config_regs apc_monitor u_mon (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .power_out(power_out), .readout_out(readout_out));
`default_nettype wire

// >>> tb/apc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apc_host_model (
    // clock
    input wire logic ref_clk_in,
    // requests
    output logic [5:0] awaddr_out,
    output logic awvalid_out,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    output logic wvalid_out,
    output logic bready_out,
    output logic [5:0] araddr_out,
    output logic arvalid_out,
    output logic rready_out,
    // answers
    input wire logic awready_in,
    input wire logic wready_in,
    input wire logic bvalid_in,
    input wire logic arready_in,
    input wire logic rvalid_in
);
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out} = '0;
        {bready_out, araddr_out, arvalid_out, rready_out} = '0;
    end
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic a_done;
        logic w_done;
        a_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk_in);
        {awaddr_out, wdata_out, wstrb_out} <= {a, 24'h0, d, 4'h1};
        {awvalid_out, wvalid_out, bready_out} <= 3'b111;
        while (!(a_done && w_done)) begin
            @(posedge ref_clk_in);
            if (!a_done && awready_in) begin
                a_done = 1'b1;
                awvalid_out <= 1'b0;
            end
            if (!w_done && wready_in) begin
                w_done = 1'b1;
                wvalid_out <= 1'b0;
            end
        end
        while (!bvalid_in) @(posedge ref_clk_in);
        bready_out <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge ref_clk_in);
        {araddr_out, arvalid_out, rready_out} <= {a, 2'b11};
        do @(posedge ref_clk_in); while (!arready_in);
        arvalid_out <= 1'b0;
        while (!rvalid_in) @(posedge ref_clk_in);
        rready_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk_in;
    logic rstn_in = 1'b0;
    logic [5:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    apc_pkg::apc_power_t pwr;
    apc_pkg::apc_readout_t ro;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [33:0] exp_q[$];
    logic [7:0] d;
    int pb[4] = '{5, 3, 1, 0};
    apc_config_regs u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .power_out(pwr), .readout_out(ro));
    apc_host_model u_host (.ref_clk_in(ref_clk_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .wdata_out(wdata),
        .wstrb_out(wstrb), .wvalid_out(wvalid), .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
        .rready_out(rready), .awready_in(awready), .wready_in(wready), .bvalid_in(bvalid), .arready_in(arready),
        .rvalid_in(rvalid));
    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        u_host.wr(a, v);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] v, input logic [1:0] r);
        exp_q.push_back({r, 24'h0, v});
        u_host.rd(a);
        repeat (2) @(posedge ref_clk_in);
    endtask
    function automatic logic [11:0] xlane(input logic par, input logic [1:0] w);
        if (par || w == 2'h3)
            return 12'h4ff;
        if (w == 2'h2)
            return 12'h233;
        return 12'h111;
    endfunction
    // answers are matched against the oldest pending note
    always @(posedge ref_clk_in) begin
        if (bvalid && bready)
            chk({bresp, 32'h0}, exp_q.pop_front());
        if (rvalid && rready)
            chk({rresp, rdata}, exp_q.pop_front());
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done;
        end
    end
    initial begin
        void'($urandom(63));
        repeat (16) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        rd(apc_pkg::POWER_DOWN_ADDR, 8'h00, apc_pkg::RESP_OKAY);
        rd(apc_pkg::PROTOCOL_ADDR, 8'h00, apc_pkg::RESP_OKAY);
        rd(apc_pkg::LANE_ADDR, 8'h00, apc_pkg::RESP_OKAY);
        chk({pwr, ro}, {4'h0, 5'h01, 2'b00, 4'h1, 8'h11});
        $display("test reset values done");
        foreach (pb[i]) begin
            d = 8'h01 << pb[i];
            wr(apc_pkg::POWER_DOWN_ADDR, d, apc_pkg::RESP_OKAY);
            rd(apc_pkg::POWER_DOWN_ADDR, d, apc_pkg::RESP_OKAY);
            chk(34'(pwr), {d[5], d[3], d[1], d[0]});
        end
        $display("test power controls done");
        for (int c = 0; c < 8; c++) begin
            d = {1'b0, 3'(c), 2'b00, 2'($urandom)};
            wr(apc_pkg::PROTOCOL_ADDR, d, apc_pkg::RESP_OKAY);
            rd(apc_pkg::PROTOCOL_ADDR, d, apc_pkg::RESP_OKAY);
            chk({ro.protocol, ro.serial_clock_polarity, ro.serial_clock_phase},
                {(d[6] ? 5'h10 : 5'h01 << d[5:4]), d[1:0]});
        end
        $display("test protocol select done");
        for (int k = 0; k < 8; k++) begin
            wr(apc_pkg::PROTOCOL_ADDR, {1'b0, k[2], 6'h00}, apc_pkg::RESP_OKAY);
            wr(apc_pkg::LANE_ADDR, {6'h00, k[1:0]}, apc_pkg::RESP_OKAY);
            rd(apc_pkg::LANE_ADDR, {6'h00, k[1:0]}, apc_pkg::RESP_OKAY);
            chk({ro.lanes_per_channel, ro.active_lane_mask}, xlane(k[2], k[1:0]));
        end
        $display("test lane count done");
        wr(6'h10, 8'h5a, apc_pkg::RESP_SLVERR);
        rd(6'h10, 8'h00, apc_pkg::RESP_SLVERR);
        rd(apc_pkg::POWER_DOWN_ADDR, 8'h01, apc_pkg::RESP_OKAY);
        $display("test unmapped address done");
        test_done;
    end
endmodule
`default_nettype wire
